// ---- rtl/rtc_control.sv ----
// RTC control register with calendar hours, shadow copy, outputs and event flags
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module rtc_control (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic kernel_tick,
	input wire logic stamp_in,
	input wire logic mains_ref_input,
	input wire logic alarm_a_match,
	input wire logic alarm_b_match,
	output logic cal_output,
	output logic event_out,
	output logic stamp_irq,
	output logic wake_irq,
	output logic alarm_a_irq,
	output logic alarm_b_irq
);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	logic ack_q;
	logic [31:0] readdata_q;
	logic [31:0] ctrl_q;
	logic [5:0] sec_q;
	logic [5:0] min_q;
	logic [4:0] hour_q;
	logic [31:0] shadow_q;
	logic [31:0] stamp_time_q;
	logic [6:0] async_pre_q;
	logic [14:0] sync_pre_q;
	logic [6:0] async_cnt_q;
	logic [14:0] sync_cnt_q;
	logic [15:0] wake_reload_q;
	logic phase_q;
	logic stamp_prev_q;
	logic ref_prev_q;
	logic wake_flag_q;
	logic stamp_flag_q;
	logic alarm_a_flag_q;
	logic alarm_b_flag_q;
	logic sync_flag_q;
	logic ref_seen_q;
	logic cal_out_q;
	logic event_out_q;

	wake_if wk ();

	// Bus access: one wait cycle, then the answer
	logic wr_en;
	logic rd_take;
	logic wr_time;
	logic wr_ctrl;
	logic wr_status;
	logic wr_pre;
	logic wr_reload;
	logic [31:0] live_word;
	logic [31:0] wdata_ctrl;
	logic [31:0] wdata_status;
	logic [31:0] wdata_time;
	logic [31:0] wdata_pre;
	logic [31:0] wdata_reload;
	assign waitrequest = (read | write) & ~ack_q;
	assign wr_en = write & ack_q;
	assign rd_take = read & ~ack_q;
	assign wr_time = wr_en & (address == rtc_ctrl_pkg::OFF_TIME);
	assign wr_ctrl = wr_en & (address == rtc_ctrl_pkg::OFF_CONTROL);
	assign wr_status = wr_en & (address == rtc_ctrl_pkg::OFF_STATUS);
	assign wr_pre = wr_en & (address == rtc_ctrl_pkg::OFF_PRESCALE);
	assign wr_reload = wr_en & (address == rtc_ctrl_pkg::OFF_WAKE_RELOAD);
	assign wdata_ctrl = merge(ctrl_q, writedata, byteenable);
	assign wdata_status = merge(32'hffff_ffff, writedata, byteenable);
	assign wdata_time = merge(live_word, writedata, byteenable);
	assign wdata_pre = merge({1'b0, sync_pre_q, 9'h000, async_pre_q}, writedata, byteenable);
	assign wdata_reload = merge({16'h0000, wake_reload_q}, writedata, byteenable);

	// Control fields
	logic [1:0] out_sel;
	logic add_hour;
	logic subtract_hour;
	logic shadow_bypass;
	assign out_sel = ctrl_q[rtc_ctrl_pkg::EVENT_OUT_SEL_LO +: 2];
	assign shadow_bypass = ctrl_q[rtc_ctrl_pkg::SHADOW_BYPASS];
	// One-shot hour adjust straight from the write, never stored
	assign add_hour = wr_ctrl & byteenable[2] & writedata[rtc_ctrl_pkg::ADD_HOUR];
	assign subtract_hour = wr_ctrl & byteenable[2] & writedata[rtc_ctrl_pkg::SUBTRACT_HOUR];

	// Prescaler chain on kernel ticks
	logic async_wrap;
	logic one_second_tick;
	assign async_wrap = kernel_tick & (async_cnt_q == 7'h00);
	assign one_second_tick = async_wrap & (sync_cnt_q == 15'h0000);

	// Calendar next state
	logic [5:0] sec_d;
	logic [5:0] min_d;
	logic [4:0] hour_d;
	logic [4:0] hour_tick;
	logic sec_wrap;
	logic min_wrap;
	assign live_word = {11'h000, hour_q, 2'h0, min_q, 2'h0, sec_q};
	assign sec_wrap = one_second_tick & (sec_q == rtc_ctrl_pkg::LAST_SEC);
	assign min_wrap = sec_wrap & (min_q == rtc_ctrl_pkg::LAST_MIN);
	assign hour_tick = !min_wrap ? hour_q : (hour_q == rtc_ctrl_pkg::LAST_HOUR) ? 5'h00 : hour_q + 5'h01;
	assign sec_d = wr_time ? wdata_time[rtc_ctrl_pkg::TIME_SEC_LO +: 6] :
		!one_second_tick ? sec_q : sec_wrap ? 6'h00 : sec_q + 6'h01;
	assign min_d = wr_time ? wdata_time[rtc_ctrl_pkg::TIME_MIN_LO +: 6] :
		!sec_wrap ? min_q : min_wrap ? 6'h00 : min_q + 6'h01;
	// Hour moves by one from the ticked value; zero hour ignores a subtract
	assign hour_d = wr_time ? wdata_time[rtc_ctrl_pkg::TIME_HOUR_LO +: 5] :
		add_hour ? ((hour_tick == rtc_ctrl_pkg::LAST_HOUR) ? 5'h00 : hour_tick + 5'h01) :
		(subtract_hour && hour_tick != 5'h00) ? hour_tick - 5'h01 : hour_tick;

	// Flag events
	logic stamp_event;
	logic ref_event;
	logic shadow_refresh;
	// Edge choice per stamp_edge_select; only while stamping is enabled
	assign stamp_event = ctrl_q[rtc_ctrl_pkg::STAMP_ENABLE] &
		(ctrl_q[rtc_ctrl_pkg::STAMP_EDGE_SELECT] ? (stamp_prev_q & ~stamp_in) : (~stamp_prev_q & stamp_in));
	// Mains reference edges are watched only when detection is on
	assign ref_event = ctrl_q[rtc_ctrl_pkg::MAINS_REF_DETECT_ENABLE] & ~ref_prev_q & mains_ref_input;
	// Every second kernel tick, unless bypassed
	assign shadow_refresh = kernel_tick & phase_q & ~shadow_bypass;

	// Wakeup timer hookup
	assign wk.enable = ctrl_q[rtc_ctrl_pkg::WAKE_TIMER_ENABLE];
	assign wk.clock_select = ctrl_q[2:0];
	assign wk.reload_value = wake_reload_q;
	assign wk.kernel_tick = kernel_tick;
	assign wk.one_second_tick = one_second_tick;

	wake_timer u_wake (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.wk(wk)
	);

	// Interrupt requests gated by their enables
	assign stamp_irq = stamp_flag_q & ctrl_q[rtc_ctrl_pkg::STAMP_IRQ_ENABLE];
	assign wake_irq = wake_flag_q & ctrl_q[rtc_ctrl_pkg::WAKE_IRQ_ENABLE];
	assign alarm_a_irq = alarm_a_flag_q & ctrl_q[rtc_ctrl_pkg::ALARM_A_IRQ_ENABLE];
	assign alarm_b_irq = alarm_b_flag_q & ctrl_q[rtc_ctrl_pkg::ALARM_B_IRQ_ENABLE];

	// Output selection and polarity
	logic event_trig;
	logic cal_wave;
	// Off selects nothing, so the pin rests at the inactive level
	assign event_trig = (out_sel == rtc_ctrl_pkg::OUT_ALARM_A) ? alarm_a_flag_q :
		(out_sel == rtc_ctrl_pkg::OUT_ALARM_B) ? alarm_b_flag_q :
		(out_sel == rtc_ctrl_pkg::OUT_WAKE) ? wake_flag_q : 1'b0;
	// Square wave: high over the upper half of the chosen prescaler period
	assign cal_wave = ctrl_q[rtc_ctrl_pkg::CAL_OUT_RATE_SELECT] ?
		(sync_cnt_q > (sync_pre_q >> 1)) : (async_cnt_q > (async_pre_q >> 1));
	assign cal_output = cal_out_q;
	assign event_out = event_out_q;

	// Read multiplexer; bypass picks the live counters
	logic [31:0] rd_mux;
	logic [31:0] status_word;
	assign status_word = {26'h0000000, ref_seen_q, sync_flag_q, alarm_b_flag_q, alarm_a_flag_q,
		stamp_flag_q, wake_flag_q};
	assign rd_mux = (address == rtc_ctrl_pkg::OFF_TIME) ? (shadow_bypass ? live_word : shadow_q) :
		(address == rtc_ctrl_pkg::OFF_CONTROL) ? ctrl_q :
		(address == rtc_ctrl_pkg::OFF_STATUS) ? status_word :
		(address == rtc_ctrl_pkg::OFF_PRESCALE) ? {1'b0, sync_pre_q, 9'h000, async_pre_q} :
		(address == rtc_ctrl_pkg::OFF_WAKE_RELOAD) ? {16'h0000, wake_reload_q} :
		(address == rtc_ctrl_pkg::OFF_STAMP_TIME) ? stamp_time_q : 32'h0000_0000;
	assign readdata = readdata_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ack_q <= 1'b0;
			readdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= (read | write) & ~ack_q;
			if (rd_take) begin
				readdata_q <= rd_mux;
			end
		end
	end

	// Only storing bits keep a value; reserved and one-shot bits read zero
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= rtc_ctrl_pkg::CONTROL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= wdata_ctrl & rtc_ctrl_pkg::CONTROL_STORE_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			async_pre_q <= rtc_ctrl_pkg::ASYNC_PRESCALE_RESET;
			sync_pre_q <= rtc_ctrl_pkg::SYNC_PRESCALE_RESET;
			wake_reload_q <= 16'h0000;
		end else begin
			if (wr_pre) begin
				async_pre_q <= wdata_pre[6:0];
				sync_pre_q <= wdata_pre[rtc_ctrl_pkg::PRESCALE_SYNC_LO +: 15];
			end
			if (wr_reload) begin
				wake_reload_q <= wdata_reload[15:0];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			async_cnt_q <= rtc_ctrl_pkg::ASYNC_PRESCALE_RESET;
			sync_cnt_q <= rtc_ctrl_pkg::SYNC_PRESCALE_RESET;
			phase_q <= 1'b0;
		end else if (kernel_tick) begin
			async_cnt_q <= async_wrap ? async_pre_q : async_cnt_q - 7'h01;
			phase_q <= ~phase_q;
			if (async_wrap) begin
				sync_cnt_q <= (sync_cnt_q == 15'h0000) ? sync_pre_q : sync_cnt_q - 15'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sec_q <= 6'h00;
			min_q <= 6'h00;
			hour_q <= 5'h00;
			shadow_q <= 32'h0000_0000;
			stamp_time_q <= 32'h0000_0000;
		end else begin
			sec_q <= sec_d;
			min_q <= min_d;
			hour_q <= hour_d;
			if (shadow_refresh) begin
				shadow_q <= live_word;
			end
			if (stamp_event) begin
				stamp_time_q <= live_word;
			end
		end
	end

	// Sticky flags: a set in the same cycle as a software clear wins
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wake_flag_q <= 1'b0;
			stamp_flag_q <= 1'b0;
			alarm_a_flag_q <= 1'b0;
			alarm_b_flag_q <= 1'b0;
			sync_flag_q <= 1'b0;
			ref_seen_q <= 1'b0;
		end else begin
			wake_flag_q <= wk.expire | (wake_flag_q & ~(wr_status & ~wdata_status[rtc_ctrl_pkg::ST_WAKE_FLAG]));
			stamp_flag_q <= stamp_event | (stamp_flag_q & ~(wr_status & ~wdata_status[rtc_ctrl_pkg::ST_STAMP_FLAG]));
			alarm_a_flag_q <= (alarm_a_match & ctrl_q[rtc_ctrl_pkg::ALARM_A_ENABLE]) |
				(alarm_a_flag_q & ~(wr_status & ~wdata_status[rtc_ctrl_pkg::ST_ALARM_A_FLAG]));
			alarm_b_flag_q <= (alarm_b_match & ctrl_q[rtc_ctrl_pkg::ALARM_B_ENABLE]) |
				(alarm_b_flag_q & ~(wr_status & ~wdata_status[rtc_ctrl_pkg::ST_ALARM_B_FLAG]));
			// Bypass holds the sync flag low
			sync_flag_q <= ~shadow_bypass & (shadow_refresh |
				(sync_flag_q & ~(wr_status & ~wdata_status[rtc_ctrl_pkg::ST_SHADOW_SYNC_FLAG])));
			ref_seen_q <= ref_event | (ref_seen_q & ~(wr_status & ~wdata_status[rtc_ctrl_pkg::ST_MAINS_REF_SEEN]));
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			stamp_prev_q <= 1'b0;
			ref_prev_q <= 1'b0;
			cal_out_q <= 1'b0;
			event_out_q <= 1'b0;
		end else begin
			stamp_prev_q <= stamp_in;
			ref_prev_q <= mains_ref_input;
			cal_out_q <= ctrl_q[rtc_ctrl_pkg::CAL_OUT_ENABLE] & cal_wave;
			event_out_q <= event_trig ^ ctrl_q[rtc_ctrl_pkg::EVENT_OUT_POLARITY];
		end
	end
endmodule
`default_nettype wire

// ---- rtl/rtc_ctrl_pkg.sv ----
// Register map, field positions, reset values and timing counts of the RTC control block
package rtc_ctrl_pkg;
	// Byte offsets on the register bus
	localparam logic [7:0] OFF_TIME = 8'h00;
	localparam logic [7:0] OFF_CONTROL = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_PRESCALE = 8'h10;
	localparam logic [7:0] OFF_WAKE_RELOAD = 8'h14;
	localparam logic [7:0] OFF_STAMP_TIME = 8'h18;

	// Control register fields
	localparam int CAL_OUT_ENABLE = 23;
	localparam int EVENT_OUT_SEL_LO = 21;
	localparam int EVENT_OUT_POLARITY = 20;
	localparam int CAL_OUT_RATE_SELECT = 19;
	localparam int DST_RECORD = 18;
	localparam int SUBTRACT_HOUR = 17;
	localparam int ADD_HOUR = 16;
	localparam int STAMP_IRQ_ENABLE = 15;
	localparam int WAKE_IRQ_ENABLE = 14;
	localparam int ALARM_B_IRQ_ENABLE = 13;
	localparam int ALARM_A_IRQ_ENABLE = 12;
	localparam int STAMP_ENABLE = 11;
	localparam int WAKE_TIMER_ENABLE = 10;
	localparam int ALARM_B_ENABLE = 9;
	localparam int ALARM_A_ENABLE = 8;
	localparam int HOUR_FORMAT = 6;
	localparam int SHADOW_BYPASS = 5;
	localparam int MAINS_REF_DETECT_ENABLE = 4;
	localparam int STAMP_EDGE_SELECT = 3;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	// Bits that store; 31:24, 17, 16 and 7 always read zero
	localparam logic [31:0] CONTROL_STORE_MASK = 32'h00fc_ff7f;

	// Status register fields
	localparam int ST_WAKE_FLAG = 0;
	localparam int ST_STAMP_FLAG = 1;
	localparam int ST_ALARM_A_FLAG = 2;
	localparam int ST_ALARM_B_FLAG = 3;
	localparam int ST_SHADOW_SYNC_FLAG = 4;
	localparam int ST_MAINS_REF_SEEN = 5;

	// Time word fields
	localparam int TIME_SEC_LO = 0;
	localparam int TIME_MIN_LO = 8;
	localparam int TIME_HOUR_LO = 16;
	localparam logic [5:0] LAST_SEC = 6'h3b;
	localparam logic [5:0] LAST_MIN = 6'h3b;
	localparam logic [4:0] LAST_HOUR = 5'h17;

	// Prescaler defaults: 32768 Hz / 128 = 256 Hz, / 256 = 1 Hz
	localparam logic [6:0] ASYNC_PRESCALE_RESET = 7'h7f;
	localparam logic [14:0] SYNC_PRESCALE_RESET = 15'h00ff;
	localparam int PRESCALE_SYNC_LO = 16;

	// Wake timer clock selection codes
	localparam logic [2:0] WAKE_DIV16 = 3'h0;
	localparam logic [2:0] WAKE_DIV8 = 3'h1;
	localparam logic [2:0] WAKE_DIV4 = 3'h2;
	localparam logic [2:0] WAKE_DIV2 = 3'h3;
	localparam int WAKE_CNT_W = 17;
	localparam logic [16:0] WAKE_EXTEND = 17'h10000;

	// Event output source codes
	localparam logic [1:0] OUT_OFF = 2'h0;
	localparam logic [1:0] OUT_ALARM_A = 2'h1;
	localparam logic [1:0] OUT_ALARM_B = 2'h2;
	localparam logic [1:0] OUT_WAKE = 2'h3;
endpackage

// ---- rtl/wake_if.sv ----
// Signals between the control register and the wakeup timer
`timescale 1ns/1ps
`default_nettype none
interface wake_if;
	logic enable;
	logic [2:0] clock_select;
	logic [15:0] reload_value;
	logic kernel_tick;
	logic one_second_tick;
	logic expire;
	modport timer (input enable, input clock_select, input reload_value, input kernel_tick,
		input one_second_tick, output expire);
	modport ctrl (output enable, output clock_select, output reload_value, output kernel_tick,
		output one_second_tick, input expire);
endinterface
`default_nettype wire

// ---- rtl/wake_timer.sv ----
// Wakeup auto-reload down counter with selectable clock
`timescale 1ns/1ps
`default_nettype none
module wake_timer (
	input wire logic ref_clk,
	input wire logic nrst,
	wake_if.timer wk
);
	logic [3:0] div_q;
	logic [rtc_ctrl_pkg::WAKE_CNT_W-1:0] cnt_q;
	logic expire_q;
	logic div_tick;
	logic step;
	logic [rtc_ctrl_pkg::WAKE_CNT_W-1:0] reload_full;

	// Kernel divided by 16, 8, 4 or 2: tick on the last kernel tick of each group
	assign div_tick = wk.kernel_tick & (
		(wk.clock_select == rtc_ctrl_pkg::WAKE_DIV16) ? (div_q == 4'hf) :
		(wk.clock_select == rtc_ctrl_pkg::WAKE_DIV8) ? (div_q[2:0] == 3'h7) :
		(wk.clock_select == rtc_ctrl_pkg::WAKE_DIV4) ? (div_q[1:0] == 2'h3) : div_q[0]);
	// Codes 1xx run from the one-second tick
	assign step = wk.clock_select[2] ? wk.one_second_tick : div_tick;
	// Codes 11x extend the reload by two to the sixteenth
	assign reload_full = {1'b0, wk.reload_value} + (wk.clock_select[2:1] == 2'h3 ?
		rtc_ctrl_pkg::WAKE_EXTEND : 17'h00000);
	assign wk.expire = expire_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div_q <= 4'h0;
		end else if (wk.kernel_tick) begin
			div_q <= div_q + 4'h1;
		end
	end

	// Disabled timer holds its reload and stays silent
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 17'h00000;
			expire_q <= 1'b0;
		end else if (!wk.enable) begin
			cnt_q <= reload_full;
			expire_q <= 1'b0;
		end else if (step) begin
			expire_q <= (cnt_q == 17'h00000);
			cnt_q <= (cnt_q == 17'h00000) ? reload_full : cnt_q - 17'h00001;
		end else begin
			expire_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- sim/rtc_control_chk.sv ----
// Port-level assertions for the RTC control block
`timescale 1ns/1ps
`default_nettype none
module rtc_control_chk (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic kernel_tick,
	input wire logic stamp_in,
	input wire logic mains_ref_input,
	input wire logic alarm_a_match,
	input wire logic alarm_b_match,
	input wire logic cal_output,
	input wire logic event_out,
	input wire logic stamp_irq,
	input wire logic wake_irq,
	input wire logic alarm_a_irq,
	input wire logic alarm_b_irq
);
	// Mirror of the control register, rebuilt from accepted bus writes
	logic [31:0] ctl_q;
	wire ctl_wr = write && !waitrequest && address == rtc_ctrl_pkg::OFF_CONTROL;
	wire [31:0] lanes = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctl_q <= rtc_ctrl_pkg::CONTROL_RESET;
		end else if (ctl_wr) begin
			ctl_q <= (ctl_q & ~lanes) | (writedata & lanes & rtc_ctrl_pkg::CONTROL_STORE_MASK);
		end
	end
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	sequence s_wait;
		(read || write) && waitrequest;
	endsequence
	sequence s_ctl_rd;
		read && !waitrequest && address == rtc_ctrl_pkg::OFF_CONTROL;
	endsequence
	sequence s_quiet(logic [1:0] src);
		ctl_q[22:21] == src && !ctl_wr;
	endsequence
	AST_WAIT_FIRST: assert property ($rose(read || write) |-> waitrequest) else $error("no wait state");
	AST_WAIT_ONE: assert property (s_wait |=> !waitrequest) else $error("wait state too long");
	AST_CTL_READ: assert property (s_ctl_rd |-> readdata == ctl_q) else $error("control readback");
	AST_CAL_OFF: assert property (!ctl_q[23] |=> !cal_output) else $error("calibration output on");
	AST_IDLE_LEVEL: assert property (s_quiet(2'h0) |=> event_out == ctl_q[20]) else $error("idle level");
	AST_A_OUT: assert property (s_quiet(2'h1) ##0 alarm_a_irq |=> event_out != ctl_q[20]) else $error("alarm out");
	AST_WAKE_OUT: assert property (s_quiet(2'h3) ##0 wake_irq |=> event_out != ctl_q[20]) else $error("wake out");
	AST_A_IRQ: assert property (alarm_a_irq |-> ctl_q[12]) else $error("alarm a irq");
	AST_B_IRQ: assert property (alarm_b_irq |-> ctl_q[13]) else $error("alarm b irq");
	AST_WAKE_IRQ: assert property (wake_irq |-> ctl_q[14]) else $error("wake irq");
	AST_STAMP_IRQ: assert property (stamp_irq |-> ctl_q[15]) else $error("stamp irq");
endmodule
bind rtc_control rtc_control_chk chk (.ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read),
	.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .kernel_tick(kernel_tick), .stamp_in(stamp_in),
	.mains_ref_input(mains_ref_input), .alarm_a_match(alarm_a_match), .alarm_b_match(alarm_b_match),
	.cal_output(cal_output), .event_out(event_out), .stamp_irq(stamp_irq), .wake_irq(wake_irq),
	.alarm_a_irq(alarm_a_irq), .alarm_b_irq(alarm_b_irq));
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the RTC control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [7:0] TIM = rtc_ctrl_pkg::OFF_TIME;
	localparam logic [7:0] CTL = rtc_ctrl_pkg::OFF_CONTROL;
	localparam logic [7:0] STS = rtc_ctrl_pkg::OFF_STATUS;
	localparam logic [7:0] PRE = rtc_ctrl_pkg::OFF_PRESCALE;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hf;
	logic kernel_tick = 1'b0;
	logic stamp_in = 1'b0;
	logic mains_ref_input = 1'b0;
	logic alarm_a_match = 1'b0;
	logic alarm_b_match = 1'b0;
	logic [31:0] readdata;
	logic [31:0] rd;
	logic waitrequest, cal_output, event_out, stamp_irq, wake_irq, alarm_a_irq, alarm_b_irq;
	logic tick_run = 1'b0;
	logic [1:0] tick_div = 2'h0;
	int ticks = 0;
	int mismatches = 0;
	int checks = 0;
	rtc_control DUT (.ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.kernel_tick(kernel_tick), .stamp_in(stamp_in), .mains_ref_input(mains_ref_input),
		.alarm_a_match(alarm_a_match), .alarm_b_match(alarm_b_match), .cal_output(cal_output),
		.event_out(event_out), .stamp_irq(stamp_irq), .wake_irq(wake_irq), .alarm_a_irq(alarm_a_irq),
		.alarm_b_irq(alarm_b_irq));
	always #10 ref_clk = ~ref_clk;
	// Kernel ticks every fourth bus clock, so shadow reads stay legal
	always @(posedge ref_clk) begin
		tick_div <= tick_run ? tick_div + 2'h1 : 2'h0;
		kernel_tick <= tick_run && tick_div == 2'h3;
		if (tick_run && tick_div == 2'h3) ticks <= ticks + 1;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic sig(input int k);
		return k == 0 ? wake_irq : k == 1 ? stamp_irq : cal_output;
	endfunction
	// Polls at the falling edge so the settled level is seen
	task automatic wait_hi(input int k, input logic v);
		int n;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (sig(k) !== v && n < 8000);
		@(posedge ref_clk);
		if (n >= 8000) begin
			mismatches++;
			finish_test();
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		// Waitrequest and read data are taken at the same rising edge
		do begin
			@(posedge ref_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge ref_clk);
		if (n >= 50) begin
			mismatches++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(s, rd, e);
	endtask
	task automatic t_regs();
		rchk("ctl reset", CTL, rtc_ctrl_pkg::CONTROL_RESET);
		rchk("pre reset", PRE, {1'b0, rtc_ctrl_pkg::SYNC_PRESCALE_RESET, 9'h0, rtc_ctrl_pkg::ASYNC_PRESCALE_RESET});
		wr(8'h04, 32'h10);
		rchk("unmapped", 8'h04, 32'h0);
		wr(CTL, rtc_ctrl_pkg::CONTROL_STORE_MASK);
		rchk("ctl store", CTL, rtc_ctrl_pkg::CONTROL_STORE_MASK);
		wr(CTL, 32'h0);
		rchk("ctl clear", CTL, 32'h0);
	endtask
	// Bypass on so the live hour is read back
	task automatic t_hour();
		wr(CTL, 32'h20);
		wr(TIM, 32'h0016_0000);
		wr(CTL, 32'h0001_0020);
		rchk("add", TIM, 32'h0017_0000);
		wr(CTL, 32'h0001_0020);
		rchk("add wrap", TIM, 32'h0);
		wr(CTL, 32'h0002_0020);
		rchk("sub zero", TIM, 32'h0);
		wr(TIM, 32'h0005_0000);
		wr(CTL, 32'h0002_0020);
		rchk("sub", TIM, 32'h0004_0000);
		wr(CTL, 32'h20);
		rchk("no adjust", TIM, 32'h0004_0000);
		rchk("adjust reads 0", CTL, 32'h20);
		bus(1'b0, STS, 32'h0);
		check("sync bypass", rd[4], 1'b0);
	endtask
	task automatic alarm_case(input logic b, input logic pol, input logic en, input logic ien);
		logic [31:0] c;
		c = {9'h0, b ? rtc_ctrl_pkg::OUT_ALARM_B : rtc_ctrl_pkg::OUT_ALARM_A, pol, 20'h0};
		c = c | (((32'(ien) << 12) | (32'(en) << 8)) << b);
		wr(CTL, c);
		alarm_a_match <= !b;
		alarm_b_match <= b;
		@(posedge ref_clk);
		alarm_a_match <= 1'b0;
		alarm_b_match <= 1'b0;
		repeat (3) @(posedge ref_clk);
		bus(1'b0, STS, 32'h0);
		check("alarm flag", rd[2 + b], en);
		check("alarm irq", b ? alarm_b_irq : alarm_a_irq, en & ien);
		check("event", event_out, en ^ pol);
		wr(STS, 32'h0);
		repeat (2) @(posedge ref_clk);
		check("event idle", event_out, pol);
	endtask
	task automatic t_shadow();
		wr(CTL, 32'h0);
		wr(STS, 32'h0);
		repeat (16) @(posedge ref_clk);
		bus(1'b0, STS, 32'h0);
		check("sync set", rd[4], 1'b1);
		wr(CTL, 32'h20);
		bus(1'b0, STS, 32'h0);
		check("sync bypass", rd[4], 1'b0);
	endtask
	// Prescale 3/1: calibration rates become 4 and 8 kernel ticks
	task automatic t_cal();
		int t0;
		wr(PRE, 32'h0001_0003);
		for (int r = 0; r < 2; r++) begin
			wr(CTL, 32'h0080_0000 | (r << 19));
			wait_hi(2, 1'b0);
			wait_hi(2, 1'b1);
			t0 = ticks;
			wait_hi(2, 1'b0);
			wait_hi(2, 1'b1);
			check("cal period", ticks - t0, r ? 8 : 4);
		end
		wr(CTL, 32'h0);
		repeat (8) @(posedge ref_clk);
		check("cal off", cal_output, 1'b0);
	endtask
	task automatic wake_period(input logic [2:0] sel, input int exp);
		int t0;
		wr(CTL, 32'h0);
		wr(STS, 32'h0);
		wr(CTL, 32'h0060_4400 | sel);
		wait_hi(0, 1'b1);
		t0 = ticks;
		wr(STS, 32'h0);
		wait_hi(0, 1'b1);
		check("wake period", ticks - t0, exp);
	endtask
	task automatic wake_quiet(input logic [31:0] c);
		wr(CTL, 32'h0);
		wr(STS, 32'h0);
		// Select settles before the enable so the first count uses it
		wr(CTL, c & ~32'h0000_0400);
		wr(CTL, c);
		repeat (256) @(posedge ref_clk);
		check("wake quiet", wake_irq, 1'b0);
	endtask
	task automatic t_stamp();
		wr(STS, 32'h0);
		wr(CTL, 32'h0000_8800);
		stamp_in <= 1'b1;
		wait_hi(1, 1'b1);
		check("stamp rise", stamp_irq, 1'b1);
		wr(STS, 32'h0);
		stamp_in <= 1'b0;
		repeat (8) @(posedge ref_clk);
		check("stamp fall ignored", stamp_irq, 1'b0);
		wr(CTL, 32'h0);
		wr(CTL, 32'h0000_0008);
		wr(CTL, 32'h0000_8808);
		stamp_in <= 1'b1;
		repeat (8) @(posedge ref_clk);
		check("stamp rise ignored", stamp_irq, 1'b0);
		stamp_in <= 1'b0;
		wait_hi(1, 1'b1);
		check("stamp fall", stamp_irq, 1'b1);
		wr(PRE, 32'h00ff_007f);
		wr(CTL, 32'h10);
		mains_ref_input <= 1'b1;
		repeat (8) @(posedge ref_clk);
		bus(1'b0, STS, 32'h0);
		check("mains seen", rd[5], 1'b1);
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		t_regs();
		t_hour();
		alarm_case(1'b0, 1'b0, 1'b1, 1'b1);
		alarm_case(1'b1, 1'b1, 1'b1, 1'b1);
		alarm_case(1'b0, 1'b1, 1'b1, 1'b0);
		alarm_case(1'b1, 1'b0, 1'b0, 1'b1);
		tick_run <= 1'b1;
		t_shadow();
		t_cal();
		wr(rtc_ctrl_pkg::OFF_WAKE_RELOAD, 32'h1);
		for (int s = 0; s < 4; s++) wake_period(3'(s), 32 >> s);
		wake_period(3'h4, 16);
		wake_quiet(32'h0060_4406);
		wake_quiet(32'h0060_4003);
		t_stamp();
		finish_test();
	end
endmodule
`default_nettype wire
